/* rtl/tsg_pkg.sv */
// package: constants, register map and carriers of the tone sequence generator
package tsg_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int SAMPLE_HZ = 8000;
	localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
	localparam int STEP_UNIT_MS = 1;
	localparam int BURST_UNIT_MS = 20;
	localparam int MS_SAMPLES = SAMPLE_HZ * STEP_UNIT_MS / 1000;
	localparam int BURST_SAMPLES = SAMPLE_HZ * BURST_UNIT_MS / 1000;

	// ----------------------------------------------------------------
	// register map: word index, byte address is index * 4
	// ----------------------------------------------------------------
	localparam logic [4:0] IDX_CONFIG = 5'h00;
	localparam logic [4:0] IDX_SWITCH = 5'h01;
	localparam logic [4:0] IDX_PITCH = 5'h02;
	localparam logic [4:0] IDX_EXTRA_PITCH = 5'h05;
	localparam logic [4:0] IDX_LEVEL = 5'h06;
	localparam logic [4:0] IDX_EXTRA_LEVEL = 5'h09;
	localparam logic [4:0] IDX_DURATION = 5'h0C;
	localparam logic [4:0] IDX_ON_PERIOD = 5'h0F;
	localparam logic [4:0] IDX_OFF_PERIOD = 5'h10;
	localparam logic [4:0] IDX_STATUS = 5'h11;
	localparam int REG_COUNT = 17;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// switch register fields and signal levels
	// ----------------------------------------------------------------
	localparam int SW_DUAL_MIX_BIT = 0;
	localparam int SW_DTMF_BIT = 1;
	localparam logic signed [15:0] FULL_SCALE = 16'sh7FFF;
	localparam logic [3:0] MAX_SHIFT = 4'h8;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// generator configuration register layout, bit 4 first
	typedef struct packed {
		logic pulsed_burst_select;
		logic sound_enable;
		logic three_step_select;
		logic step_cycler_enable;
		logic square_wave_select;
	} tsg_cfg_t;

	// one produced sample
	typedef struct packed {
		logic valid;
		logic signed [15:0] value;
	} tsg_sample_t;
endpackage

/* rtl/tsg_shaper.sv */
// one signal generator: phase accumulator, trapezoid or square shape, level
`timescale 1ns/1ns
module tsg_shaper (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic sample_en,
	input wire logic square_en,
	input wire logic [15:0] generator_pitch,
	input wire logic [7:0] generator_level,
	// result
	output logic signed [15:0] wave_ff
);
	import tsg_pkg::*;

	logic [15:0] phase_ff;
	logic [14:0] fold;
	logic signed [17:0] tri_s;
	logic signed [17:0] trap_s;
	logic signed [15:0] shaped;
	logic [3:0] shift;

	// phase advances one pitch step per sample (pitch 32768 gives half the sample rate)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_ff <= 16'h0000;
		end else if (sample_en) begin
			phase_ff <= phase_ff + generator_pitch;
		end
	end

	// triangle doubled and clipped gives the flat-topped shape
	always_comb begin
		fold = phase_ff[15] ? ~phase_ff[14:0] : phase_ff[14:0];
		tri_s = $signed({2'b00, fold, 1'b0}) - 18'sh08000;
		trap_s = tri_s <<< 1;
		if (square_en) begin
			shaped = phase_ff[15] ? -FULL_SCALE : FULL_SCALE;
		end else if (trap_s > 18'sh07FFF) begin
			shaped = FULL_SCALE;
		end else if (trap_s < -18'sh07FFF) begin
			shaped = -FULL_SCALE;
		end else begin
			shaped = trap_s[15:0];
		end
		// 6 dB per level unit, clamped at the bottom of the range
		shift = (generator_level > 8'(MAX_SHIFT)) ? MAX_SHIFT : generator_level[3:0];
	end

	// output register moves only on the sample enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wave_ff <= 16'sh0000;
		end else if (sample_en) begin
			wave_ff <= shaped >>> shift;
		end
	end

	a_square_full: assert property (@(posedge aclk) disable iff (!aresetn)
		(sample_en && square_en && generator_level == 8'h00) |=> (wave_ff == FULL_SCALE || wave_ff == -FULL_SCALE))
		else $error("square output at 0 dB is not full scale");
endmodule

/* rtl/tsg_top.sv */
// tone sequence generator: register slave, four generators, step cycler, mixer
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
module tsg_top #(
	parameter int SAMPLE_DIV = tsg_pkg::SAMPLE_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// tone stream
	output tsg_pkg::tsg_sample_t tone_out
);
	import tsg_pkg::*;

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	logic [15:0] regs_ff [0:REG_COUNT-1];
	logic aw_got_ff;
	logic w_got_ff;
	logic [4:0] waddr_ff;
	logic wbad_ff;
	logic [15:0] wdata_ff;
	logic [1:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic do_write;
	logic [31:0] status_word;
	tsg_cfg_t cfg;
	logic dual_mix_enable;

	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready = !w_got_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
	assign cfg = tsg_cfg_t'(regs_ff[IDX_CONFIG][4:0]);
	assign dual_mix_enable = regs_ff[IDX_SWITCH][SW_DUAL_MIX_BIT];

	// address and data are caught in either order, then written together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			waddr_ff <= 5'h00;
			wbad_ff <= 1'b0;
			wdata_ff <= 16'h0000;
			wstrb_ff <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				waddr_ff <= s_axi_awaddr[6:2];
				wbad_ff <= s_axi_awaddr[7] || (s_axi_awaddr[6:2] >= 5'(REG_COUNT));
			end else if (do_write) begin
				aw_got_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata[15:0];
				wstrb_ff <= s_axi_wstrb[1:0];
			end else if (do_write) begin
				w_got_ff <= 1'b0;
			end
		end
	end

	// register array; upper bytes of each word are not stored and read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_ff[i] <= REG_RESET;
			end
		end else if (do_write && !wbad_ff) begin
			if (wstrb_ff[0]) begin
				regs_ff[waddr_ff][7:0] <= wdata_ff[7:0];
			end
			if (wstrb_ff[1]) begin
				regs_ff[waddr_ff][15:8] <= wdata_ff[15:8];
			end
		end
	end

	// write response; unmapped words answer slverr and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= AXI_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wbad_ff ? AXI_SLVERR : AXI_OKAY;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= AXI_OKAY;
			if (s_axi_araddr[6:2] == IDX_STATUS && !s_axi_araddr[7]) begin
				rdata_ff <= status_word;
			end else if (s_axi_araddr[6:2] < 5'(REG_COUNT) && !s_axi_araddr[7]) begin
				rdata_ff <= {16'h0000, regs_ff[s_axi_araddr[6:2]]};
			end else begin
				rdata_ff <= 32'h00000000;
				rresp_ff <= AXI_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// sample, millisecond and burst-unit enables
	// ----------------------------------------------------------------
	logic [15:0] div_ff;
	logic sample_tick;
	logic [3:0] ms_div_ff;
	logic ms_tick;
	logic [7:0] burst_div_ff;
	logic burst_tick;

	assign sample_tick = (div_ff == 16'(SAMPLE_DIV - 1));
	assign ms_tick = sample_tick && (ms_div_ff == 4'(MS_SAMPLES - 1));
	assign burst_tick = sample_tick && (burst_div_ff == 8'(BURST_SAMPLES - 1));

	// one divider chain from the core clock, no second clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_ff <= 16'h0000;
			ms_div_ff <= 4'h0;
			burst_div_ff <= 8'h00;
		end else begin
			div_ff <= sample_tick ? 16'h0000 : div_ff + 16'h0001;
			if (sample_tick) begin
				ms_div_ff <= ms_tick ? 4'h0 : ms_div_ff + 4'h1;
				burst_div_ff <= burst_tick ? 8'h00 : burst_div_ff + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// step cycler
	// ----------------------------------------------------------------
	logic [1:0] step_idx_ff;
	logic [15:0] step_cnt_ff;
	logic [1:0] last_idx;
	logic [15:0] cur_duration;
	logic step_done;
	logic [1:0] nxt_step_idx;

	assign last_idx = cfg.three_step_select ? 2'h2 : 2'h1;
	assign cur_duration = regs_ff[IDX_DURATION + 5'(step_idx_ff)];
	// a zero duration still holds the step for one unit
	assign step_done = ms_tick && (step_cnt_ff + 16'h0001 >= cur_duration);
	assign nxt_step_idx = (step_idx_ff >= last_idx) ? 2'h0 : step_idx_ff + 2'h1;

	// duration counted in millisecond units, 16 bits reach past 65 s
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_idx_ff <= 2'h0;
			step_cnt_ff <= 16'h0000;
		end else if (!cfg.step_cycler_enable) begin
			step_idx_ff <= cfg.three_step_select ? 2'h1 : 2'h0;
			step_cnt_ff <= 16'h0000;
		end else if (step_idx_ff > last_idx) begin
			step_idx_ff <= 2'h0;
			step_cnt_ff <= 16'h0000;
		end else if (step_done) begin
			step_idx_ff <= nxt_step_idx;
			step_cnt_ff <= 16'h0000;
		end else if (ms_tick) begin
			step_cnt_ff <= step_cnt_ff + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// burst gate
	// ----------------------------------------------------------------
	logic burst_on_ff;
	logic [15:0] burst_cnt_ff;
	logic [15:0] burst_len;
	logic gate;

	assign burst_len = burst_on_ff ? regs_ff[IDX_ON_PERIOD] : regs_ff[IDX_OFF_PERIOD];
	assign gate = cfg.pulsed_burst_select ? burst_on_ff : cfg.sound_enable;

	// on and off periods in 20 ms units, starting with the on period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_on_ff <= 1'b1;
			burst_cnt_ff <= 16'h0000;
		end else if (!cfg.pulsed_burst_select) begin
			burst_on_ff <= 1'b1;
			burst_cnt_ff <= 16'h0000;
		end else if (burst_tick) begin
			if (burst_cnt_ff + 16'h0001 >= burst_len) begin
				burst_on_ff <= !burst_on_ff;
				burst_cnt_ff <= 16'h0000;
			end else begin
				burst_cnt_ff <= burst_cnt_ff + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// generators and mixer
	// ----------------------------------------------------------------
	logic signed [15:0] gen_wave [0:3];
	logic signed [15:0] base;
	logic signed [16:0] mix;
	logic signed [15:0] mix_sat;

	// three shaped generators; square select only reaches these
	for (genvar g = 0; g < 3; g++) begin : gen_shaped
		tsg_shaper u_shaper (
			.aclk(aclk),
			.aresetn(aresetn),
			.sample_en(sample_tick),
			.square_en(cfg.square_wave_select),
			.generator_pitch(regs_ff[IDX_PITCH + 5'(g)]),
			.generator_level(regs_ff[IDX_LEVEL + 5'(g)][7:0]),
			.wave_ff(gen_wave[g])
		);
	end

	// extra generator: level follows the active step index
	tsg_shaper u_extra (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_en(sample_tick),
		.square_en(1'b0),
		.generator_pitch(regs_ff[IDX_EXTRA_PITCH]),
		.generator_level(regs_ff[IDX_EXTRA_LEVEL + 5'(step_idx_ff)][7:0]),
		.wave_ff(gen_wave[3])
	);

	// the dtmf bit is only stored; keeping it apart from dual-mix is software's job
	always_comb begin
		base = gen_wave[step_idx_ff];
		mix = 17'(base) + (dual_mix_enable ? 17'(gen_wave[3]) : 17'sh00000);
		if (mix > 17'sh07FFF) begin
			mix_sat = FULL_SCALE;
		end else if (mix < -17'sh07FFF) begin
			mix_sat = -FULL_SCALE;
		end else begin
			mix_sat = mix[15:0];
		end
	end

	// one output word per sample, silent while the gate is shut
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tone_out <= '0;
		end else begin
			tone_out.valid <= sample_tick;
			if (sample_tick) begin
				tone_out.value <= gate ? mix_sat : 16'sh0000;
			end
		end
	end

	assign status_word = {tone_out.value, 13'h0000, gate, step_idx_ff};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_step_end;
		cfg.step_cycler_enable && step_idx_ff <= last_idx && step_done;
	endsequence

	a_idx_range: assert property (step_idx_ff != 2'h3)
		else $error("step index out of range");
	a_cont_pick: assert property (!cfg.step_cycler_enable ##1 !cfg.step_cycler_enable |->
		step_idx_ff == ($past(cfg.three_step_select) ? 2'h1 : 2'h0))
		else $error("continuous mode picked wrong generator");
	a_step_wrap: assert property (s_step_end |=> step_idx_ff == $past(nxt_step_idx))
		else $error("step did not advance or wrap");
	a_two_step: assert property ((cfg.step_cycler_enable && !cfg.three_step_select) [*2] |->
		step_idx_ff != 2'h2)
		else $error("two-step sequence reached third generator");
	a_step_hold: assert property ((cfg.step_cycler_enable && !step_done && !ms_tick &&
		step_idx_ff <= last_idx) |=> $stable(step_idx_ff) || !$past(cfg.step_cycler_enable))
		else $error("step changed before its duration");
	a_silence: assert property ((sample_tick && !gate) |=> tone_out.valid && tone_out.value == 16'sh0000)
		else $error("output not silent with gate shut");
	a_plain_pass: assert property ((sample_tick && gate && !dual_mix_enable) |=>
		tone_out.value == $past(base))
		else $error("output differs from selected generator");
	a_bresp_pair: assert property ($rose(s_axi_bvalid) |-> $past(aw_got_ff) && $past(w_got_ff))
		else $error("write answered before address and data");
	a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read not answered next cycle");
endmodule

/* sim/tsg_top_test.sv */
// self-checking testbench of the tone sequence generator top
`timescale 1ns/1ns
module tsg_top_test;
	import tsg_pkg::*;
	// ----------------------------------------------------------------
	// bench signals and model state
	// ----------------------------------------------------------------
	// small divider keeps a 1 ms step at 32 clocks so sequences finish quickly
	localparam int DIV = 4;
	localparam int MS_CYC = DIV * MS_SAMPLES;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	tsg_sample_t tone_out;
	int bad_count = 0;
	int cmp_count = 0;
	int seed = 32'hefe2e586;
	int cyc = 0;
	int last_pulse = -1;
	logic [15:0] shadow [REG_COUNT];
	// coefficient set for the tone scenarios, one entry per word index
	logic [15:0] setup [REG_COUNT] = '{16'h0000, 16'h0000, 16'h1000, 16'h1000, 16'h1000, 16'h0800,
		16'h0008, 16'h0008, 16'h0008, 16'h0000, 16'h0008, 16'h0000, 16'h0002, 16'h0001, 16'h0003,
		16'h0001, 16'h0001};

	always #2 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	tsg_top #(.SAMPLE_DIV(DIV)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tone_out(tone_out)
	);

	// ----------------------------------------------------------------
	// compare and verdict
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// axi4-lite master; a response code of 3 means no answer came
	// ----------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h3;
		for (n = 0; n < 50 && r === 2'h3; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
			end
		end
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r = 2'h3;
		for (n = 0; n < 50 && r === 2'h3; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask

	// write one word and keep the model in step
	task put(input int i, input logic [15:0] v);
		logic [1:0] r;
		wr(8'(i * 4), {16'h0000, v}, 4'h3, r);
		check(r, AXI_OKAY);
		shadow[i] = v;
	endtask

	// bits that a word holds; other low-half bits are not compared, the upper half must read zero
	function automatic logic [31:0] msk(input int i);
		if (i == IDX_CONFIG) return 32'h0000_001F;
		if (i == IDX_SWITCH) return 32'h0000_0003;
		if (i >= IDX_LEVEL && i < IDX_DURATION) return 32'h0000_00FF;
		return 32'h0000_FFFF;
	endfunction

	task reg_chk(input int i);
		logic [31:0] d;
		logic [1:0] r;
		rd(8'(i * 4), d, r);
		check(r, AXI_OKAY);
		check(d & (msk(i) | 32'hFFFF_0000), {16'h0000, shadow[i]} & msk(i));
	endtask

	// ----------------------------------------------------------------
	// tone stream observers
	// ----------------------------------------------------------------
	// samples arrive exactly once per divider period
	always @(posedge aclk) begin
		if (aresetn && tone_out.valid === 1'b1) begin
			if (last_pulse >= 0) check(cyc - last_pulse, DIV);
			last_pulse <= cyc;
		end
	end

	task stats(input int n, output int maxa, output int zeros, output int mids);
		int k, a;
		logic signed [15:0] v;
		maxa = 0;
		zeros = 0;
		mids = 0;
		// the first samples after a setting change still carry the old selection and extra level
		repeat (3) begin
			@(posedge aclk);
			while (tone_out.valid !== 1'b1) @(posedge aclk);
		end
		for (k = 0; k < n; k++) begin
			@(posedge aclk);
			while (tone_out.valid !== 1'b1) @(posedge aclk);
			v = tone_out.value;
			a = v;
			if (a < 0) a = -a;
			if (a > maxa) maxa = a;
			if (a == 0) zeros++;
			if (a > 'h1000 && a < 'h7000) mids++;
		end
	endtask

	// follows the step index and times each completed step
	task steps(input int len, input int n);
		int prev, t0, k, seen, dw;
		logic [31:0] d;
		logic [1:0] r;
		rd(8'(IDX_STATUS * 4), d, r);
		prev = d[1:0];
		t0 = -1;
		seen = 0;
		for (k = 0; k < 600 && seen < n; k++) begin
			rd(8'(IDX_STATUS * 4), d, r);
			if (d[1:0] != prev) begin
				check(d[1:0], (prev + 1) % len);
				dw = cyc - t0 - shadow[IDX_DURATION + prev] * MS_CYC;
				if (t0 >= 0) check(dw <= 8 && dw >= -8, 1'b1);
				t0 = cyc;
				prev = d[1:0];
				seen++;
			end
		end
		check(seen, n);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int i, mx, z, md;
		logic [31:0] d;
		logic [1:0] r;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// every word, status included, starts at zero
		for (i = 0; i <= IDX_STATUS; i++) begin
			rd(8'(i * 4), d, r);
			check(d, 32'h0000_0000);
		end
		// random words with random upper halves, dtmf mode kept clear
		for (i = 0; i < REG_COUNT; i++) begin
			d = $random(seed);
			if (i == IDX_SWITCH) d[SW_DTMF_BIT] = 1'b0;
			wr(8'(i * 4), d, 4'h3, r);
			check(r, AXI_OKAY);
			shadow[i] = d[15:0];
		end
		for (i = 0; i < REG_COUNT; i++) reg_chk(i);
		// a single strobe touches only the low byte
		wr(8'(IDX_PITCH * 4), 32'h0000_ABCD, 4'h1, r);
		check(r, AXI_OKAY);
		shadow[IDX_PITCH][7:0] = 8'hCD;
		reg_chk(IDX_PITCH);
		// read-only status, unmapped word and high address are refused
		wr(8'h44, 32'h0000_FFFF, 4'h3, r);
		check(r, AXI_SLVERR);
		wr(8'h80, 32'h0000_FFFF, 4'h3, r);
		check(r, AXI_SLVERR);
		reg_chk(IDX_CONFIG);
		rd(8'h48, d, r);
		check(d, 32'h0000_0000);
		check(r, AXI_SLVERR);
		rd(8'h80, d, r);
		check(d, 32'h0000_0000);
		check(r, AXI_SLVERR);
		for (i = 0; i < REG_COUNT; i++) put(i, setup[i]);
		// silence while sound and burst are both off
		stats(32, mx, z, md);
		check(z, 32);
		// full-level square on generator one, then trapezoid
		put(IDX_LEVEL, 16'h0000);
		put(IDX_CONFIG, 16'h0009);
		stats(64, mx, z, md);
		check(mx >= 'h7FFF, 1'b1);
		check(md, 32'h0000_0000);
		rd(8'(IDX_STATUS * 4), d, r);
		check(d[2:0], 3'h4);
		put(IDX_CONFIG, 16'h0008);
		stats(64, mx, z, md);
		check(md > 0, 1'b1);
		// continuous generator two at one level step down
		put(IDX_LEVEL + 1, 16'h0001);
		put(IDX_CONFIG, 16'h000D);
		stats(64, mx, z, md);
		check(mx == 'h3FFF || mx == 'h4000, 1'b1);
		rd(8'(IDX_STATUS * 4), d, r);
		check(d[1:0], 2'h1);
		// dual mix: the extra level follows the continuous generator
		put(IDX_LEVEL + 1, 16'h0008);
		put(IDX_SWITCH, 16'h0001);
		put(IDX_CONFIG, 16'h0009);
		stats(64, mx, z, md);
		check({mx > 'h1000, md > 0}, 2'b11);
		put(IDX_CONFIG, 16'h000D);
		stats(64, mx, z, md);
		check(mx <= 'h100, 1'b1);
		put(IDX_SWITCH, 16'h0000);
		put(IDX_CONFIG, 16'h0009);
		stats(64, mx, z, md);
		// without dual mix the full-level square stays pure: full scale, nothing in between
		check(mx >= 'h7FFF, 1'b1);
		check(md, 32'h0000_0000);
		// two-step and three-step sequences with uneven durations
		put(IDX_CONFIG, 16'h000A);
		steps(2, 6);
		put(IDX_CONFIG, 16'h000E);
		steps(3, 7);
		// pulsed bursts with and without sound enable
		put(IDX_LEVEL, 16'h0000);
		for (i = 0; i < 2; i++) begin
			put(IDX_CONFIG, i ? 16'h0019 : 16'h0011);
			stats(400, mx, z, md);
			check(z >= 80 && z <= 320, 1'b1);
		end
		finish_test;
	end

	// watchdog, far beyond the roughly 6k clocks the sequence needs
	initial begin
		#200000;
		bad_count++;
		finish_test;
	end
endmodule
